// File: cef_pkg.sv
/*
  Package for the converter event flag and interrupt block: register map,
  flag positions, reset values and bus carrier types.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package cef_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0] CEF_OFS_STATUS = 4'h0;
  localparam logic [3:0] CEF_OFS_ENABLE = 4'h4;
  localparam logic [3:0] CEF_OFS_CFGCMD = 4'h8;
  localparam logic [31:0] CEF_RESET_VAL = 32'h00000000;

  // ---------------------------------------------------------------
  // Flag positions
  // ---------------------------------------------------------------
  localparam int CEF_BIT_CFGRDY = 13;
  localparam int CEF_BIT_CALIB = 11;
  localparam int CEF_BIT_WDOG3 = 9;
  localparam int CEF_BIT_WDOG2 = 8;
  localparam int CEF_BIT_WDOG1 = 7;
  localparam int CEF_BIT_OVERRUN = 4;
  localparam int CEF_BIT_SEQ = 3;
  localparam int CEF_BIT_CONV = 2;
  localparam int CEF_BIT_SAMP = 1;
  localparam int CEF_BIT_RDY = 0;
  localparam logic [31:0] CEF_IMPL_MASK = 32'h00002B9F;

  // Control register of own layout
  localparam int CEF_BIT_START = 0;
  localparam int CEF_BIT_ENCMD = 1;
  localparam int CEF_BIT_CFGWR = 2;

  // ---------------------------------------------------------------
  // Bus response codes
  // ---------------------------------------------------------------
  localparam logic [1:0] CEF_RESP_OKAY = 2'h0;
  localparam logic [1:0] CEF_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [3:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [3:0] araddr;
    logic rready;
  } cef_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cef_axi_rsp_t;

  // Event pulses from the conversion engine
  typedef struct packed {
    logic cfg_applied;
    logic calib_done;
    logic wdog_three;
    logic wdog_two;
    logic wdog_one;
    logic seq_done;
    logic conv_done;
    logic samp_done;
    logic conv_ready;
    logic data_read;
  } cef_events_t;

endpackage

// File: cef_flags.sv
/*
  Sticky flag bank: set by hardware events, cleared by write-one.
  Assumes events and clears are single-cycle pulses on i_mclk.
*/
`timescale 1ns/10ps
module cef_flags (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Set and clear vectors
  input wire logic [31:0] i_set,
  input wire logic [31:0] i_clr,
  // Flag state
  output logic [31:0] o_flags
);
  import cef_pkg::*;

  typedef struct packed {
    logic [31:0] flags;
  } cef_flags_state_t;

  cef_flags_state_t st;
  cef_flags_state_t next_st;

  always_comb begin
    next_st = st;
    // Set beats clear; reserved bits stay zero
    next_st.flags = ((st.flags & ~i_clr) | i_set) & CEF_IMPL_MASK;
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      st <= '{flags: CEF_RESET_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign o_flags = st.flags;
endmodule // cef_flags

// File: cef_irq.sv
/*
  Converter event flags and interrupt controller with AXI4-Lite slave.
  Assumes event inputs are one-cycle pulses synchronous to i_mclk.
*/
// How it works
// - Channel-configuration-ready flag (bit 13) sets once a configuration change is applied; write 1 clears it.
// - A new configuration or start command in a later write before that flag rises is ignored; a start in the configuring write is accepted.
// - Calibration-done flag (bit 11) sets on calibration end; write 1 clears it.
// - Watchdog-3 flag (bit 9) sets on a watchdog-3 threshold crossing; write 1 clears it.
// - Watchdog-2 flag (bit 8) sets on a watchdog-2 threshold crossing; write 1 clears it.
// - Watchdog-1 flag (bit 7) sets on a watchdog-1 threshold crossing; write 1 clears it.
// - Overrun flag (bit 4) sets when a conversion ends while conversion-done is still set.
// - Sequence-done flag (bit 3) sets after the last channel is converted; write 1 clears it.
// - Conversion-done flag (bit 2) sets per result; cleared by write 1 or data read.
// - Sampling-done flag (bit 1) sets at the end of each sampling phase; write 1 clears it.
// - Ready flag (bit 0) sets once the enabled converter can accept requests; write 1 clears it.
// - Status and enable reset to zero and reserved bits stay zero.
// - Enable register holds read-write enables, writes ignored while a start command is set; 1 enables the matching interrupt.
// - Overrun, sequence and conversion enables request an interrupt while their flag is set.
`timescale 1ns/10ps
module cef_irq (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Register bus
  input wire cef_pkg::cef_axi_req_t i_axi,
  output cef_pkg::cef_axi_rsp_t o_axi,
  // Conversion engine events and state
  input wire cef_pkg::cef_events_t i_evt,
  input wire logic i_start_clear,
  // Commands to the conversion engine
  output logic o_start_cmd,
  output logic o_enable_cmd,
  output logic o_cfg_write,
  // Interrupt
  output logic o_irq
);
  import cef_pkg::*;

  typedef struct packed {
    cef_axi_rsp_t axi;
    logic aw_held;
    logic [3:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] enable;
    logic start_cmd;
    logic enable_cmd;
    logic cfg_pending;
    logic cfg_write;
    logic irq;
  } cef_state_t;

  cef_state_t st;
  cef_state_t next_st;
  logic [31:0] flags;
  logic [31:0] flag_set;
  logic [31:0] flag_clr;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  function automatic logic addr_ok(input logic [3:0] a);
    return (a == CEF_OFS_STATUS) || (a == CEF_OFS_ENABLE) ||
      (a == CEF_OFS_CFGCMD);
  endfunction

  // ---------------------------------------------------------------
  // Flag bank
  // ---------------------------------------------------------------
  cef_flags u_flags (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_set(flag_set),
    .i_clr(flag_clr),
    .o_flags(flags)
  );

  logic wr_go;
  logic [31:0] wr_bits;
  logic rd_go;
  logic cfg_req;

  always_comb begin
    wr_go = st.aw_held && st.w_held && !st.axi.bvalid;
    wr_bits = st.w_data & strb_mask(st.w_strb);
    rd_go = i_axi.arvalid && !st.axi.rvalid;
    cfg_req = wr_go && (st.aw_addr == CEF_OFS_CFGCMD) &&
      wr_bits[CEF_BIT_CFGWR];

    flag_set = '0;
    flag_set[CEF_BIT_CFGRDY] = i_evt.cfg_applied && st.cfg_pending;
    flag_set[CEF_BIT_CALIB] = i_evt.calib_done;
    flag_set[CEF_BIT_WDOG3] = i_evt.wdog_three;
    flag_set[CEF_BIT_WDOG2] = i_evt.wdog_two;
    flag_set[CEF_BIT_WDOG1] = i_evt.wdog_one;
    flag_set[CEF_BIT_OVERRUN] = i_evt.conv_done && flags[CEF_BIT_CONV];
    flag_set[CEF_BIT_SEQ] = i_evt.seq_done;
    flag_set[CEF_BIT_CONV] = i_evt.conv_done;
    flag_set[CEF_BIT_SAMP] = i_evt.samp_done;
    flag_set[CEF_BIT_RDY] = i_evt.conv_ready && st.enable_cmd;

    // Write-one clears; zeros leave flags alone
    flag_clr = '0;
    if (wr_go && st.aw_addr == CEF_OFS_STATUS) begin
      flag_clr = wr_bits;
    end
    if (i_evt.data_read) begin
      flag_clr[CEF_BIT_CONV] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.cfg_write = 1'b0;
    next_st.axi.awready = !st.aw_held && !i_axi.awvalid ? 1'b0 :
      !st.aw_held && !st.axi.awready;
    next_st.axi.wready = !st.w_held && !i_axi.wvalid ? 1'b0 :
      !st.w_held && !st.axi.wready;

    // Capture address and data in either order
    if (i_axi.awvalid && st.axi.awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = i_axi.awaddr;
      next_st.axi.awready = 1'b0;
    end
    if (i_axi.wvalid && st.axi.wready) begin
      next_st.w_held = 1'b1;
      next_st.w_data = i_axi.wdata;
      next_st.w_strb = i_axi.wstrb;
      next_st.axi.wready = 1'b0;
    end

    if (wr_go) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.axi.bvalid = 1'b1;
      next_st.axi.bresp = addr_ok(st.aw_addr) ? CEF_RESP_OKAY :
        CEF_RESP_SLVERR;
      if (st.aw_addr == CEF_OFS_ENABLE && !st.start_cmd) begin
        next_st.enable = (st.enable & ~strb_mask(st.w_strb)) |
          (wr_bits & CEF_IMPL_MASK);
      end
      if (st.aw_addr == CEF_OFS_CFGCMD) begin
        if (st.w_strb[0]) begin
          next_st.enable_cmd = wr_bits[CEF_BIT_ENCMD];
        end
        // Start refused while a configuration is still pending
        if (wr_bits[CEF_BIT_START] && st.enable_cmd &&
            !st.cfg_pending) begin
          next_st.start_cmd = 1'b1;
        end
        // New configuration refused until the last one applied
        if (cfg_req && !st.cfg_pending) begin
          next_st.cfg_pending = 1'b1;
          next_st.cfg_write = 1'b1;
        end
      end
    end
    if (st.axi.bvalid && i_axi.bready) begin
      next_st.axi.bvalid = 1'b0;
    end

    if (i_evt.cfg_applied) begin
      next_st.cfg_pending = 1'b0;
    end
    if (i_start_clear) begin
      next_st.start_cmd = 1'b0;
    end
    if (!next_st.enable_cmd) begin
      next_st.start_cmd = 1'b0;
    end

    // Read channel
    next_st.axi.arready = rd_go && !st.axi.arready;
    if (rd_go && st.axi.arready) begin
      next_st.axi.rvalid = 1'b1;
      next_st.axi.rresp = addr_ok(i_axi.araddr) ? CEF_RESP_OKAY :
        CEF_RESP_SLVERR;
      case (i_axi.araddr)
        CEF_OFS_STATUS: next_st.axi.rdata = flags;
        CEF_OFS_ENABLE: next_st.axi.rdata = st.enable;
        CEF_OFS_CFGCMD: begin
          next_st.axi.rdata = '0;
          next_st.axi.rdata[CEF_BIT_START] = st.start_cmd;
          next_st.axi.rdata[CEF_BIT_ENCMD] = st.enable_cmd;
          next_st.axi.rdata[CEF_BIT_CFGWR] = st.cfg_pending;
        end
        default: next_st.axi.rdata = '0;
      endcase
    end
    if (st.axi.rvalid && i_axi.rready) begin
      next_st.axi.rvalid = 1'b0;
    end

    next_st.irq = |(flags & st.enable);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_axi = st.axi;
  assign o_start_cmd = st.start_cmd;
  assign o_enable_cmd = st.enable_cmd;
  assign o_cfg_write = st.cfg_write;
  assign o_irq = st.irq;
endmodule // cef_irq

// File: cef_irq_sva.sv
/*
  Checker for the converter event flag block, bound to cef_irq.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module cef_irq_sva (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Bus and engine side
  input wire cef_pkg::cef_axi_req_t i_axi,
  input wire cef_pkg::cef_axi_rsp_t o_axi,
  input wire cef_pkg::cef_events_t i_evt,
  input wire logic i_start_clear,
  // Watched outputs
  input wire logic o_start_cmd,
  input wire logic o_enable_cmd,
  input wire logic o_cfg_write,
  input wire logic o_irq
);
  import cef_pkg::*;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  rst_quiet_a: assert property ($fell(i_sys_rst) |->
    !o_irq && !o_start_cmd && !o_enable_cmd) else $error("dirty reset");
  b_once_a: assert property (o_axi.bvalid && i_axi.bready |=>
    !o_axi.bvalid) else $error("write response repeated");
  r_once_a: assert property (o_axi.rvalid && i_axi.rready |=>
    !o_axi.rvalid) else $error("read response repeated");
  aw_pulse_a: assert property (o_axi.awready |=>
    !o_axi.awready) else $error("awready longer than one cycle");
  r_lat_a: assert property (i_axi.arvalid && o_axi.arready |=>
    o_axi.rvalid) else $error("read data late");
  bad_rd_a: assert property (i_axi.arvalid && o_axi.arready &&
    i_axi.araddr == 4'hC |=> o_axi.rresp == CEF_RESP_SLVERR &&
    o_axi.rdata == '0) else $error("unmapped read not refused");
  stat_resv_a: assert property (i_axi.arvalid && o_axi.arready &&
    i_axi.araddr == CEF_OFS_STATUS |=> (o_axi.rdata & ~CEF_IMPL_MASK)
    == '0) else $error("reserved status bit set");
  cfg_pulse_a: assert property (o_cfg_write |=>
    !o_cfg_write) else $error("config pulse too long");
  start_en_a: assert property ($rose(o_start_cmd) |->
    o_enable_cmd) else $error("start without enable");
  start_clr_a: assert property (i_start_clear |=>
    !o_start_cmd) else $error("start not cleared");
endmodule // cef_irq_sva

bind cef_irq cef_irq_sva u_sva (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
  .i_axi(i_axi), .o_axi(o_axi), .i_evt(i_evt),
  .i_start_clear(i_start_clear), .o_start_cmd(o_start_cmd),
  .o_enable_cmd(o_enable_cmd), .o_cfg_write(o_cfg_write), .o_irq(o_irq));

// File: converter_event_flags_irq_bench.sv
/*
  Self-checking bench for cef_irq: AXI4-Lite tasks and event pulses.
  Assumes the checker is bound in by its own file.
*/
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  n_fail++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end

module converter_event_flags_irq_bench;
  import cef_pkg::*;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  cef_axi_req_t rq = '0;
  cef_axi_rsp_t rs;
  cef_events_t evt = '0;
  logic stc = 1'b0;
  logic o_start_cmd, o_enable_cmd, o_cfg_write, o_irq;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int n_cfg = 0;
  logic [31:0] d;
  int ix[6] = '{8, 7, 6, 5, 4, 2};
  int bt[6] = '{11, 9, 8, 7, 3, 1};

  cef_irq DUT (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_axi(rq),
    .o_axi(rs), .i_evt(evt), .i_start_clear(stc),
    .o_start_cmd(o_start_cmd), .o_enable_cmd(o_enable_cmd),
    .o_cfg_write(o_cfg_write), .o_irq(o_irq));

  initial forever #50 i_mclk = ~i_mclk;

  // Counts configuration write pulses sent to the engine
  always @(posedge i_mclk) begin
    if (o_cfg_write === 1'b1) n_cfg++;
  end

  task print_verdict;
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  // ----
  // Bus and event tasks
  // ----
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_mclk);
    rq.awvalid <= 1'b1;
    rq.awaddr <= a;
    rq.wvalid <= 1'b1;
    rq.wdata <= v;
    rq.wstrb <= 4'hF;
    rq.bready <= 1'b1;
    do begin
      @(posedge i_mclk);
      if (rs.awready) rq.awvalid <= 1'b0;
      if (rs.wready) rq.wvalid <= 1'b0;
    end while (!rs.bvalid);
    rq.bready <= 1'b0;
    `CHK("bresp", a > 4'h8 ? CEF_RESP_SLVERR : CEF_RESP_OKAY, rs.bresp)
  endtask

  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_mclk);
    rq.arvalid <= 1'b1;
    rq.araddr <= a;
    rq.rready <= 1'b1;
    do begin
      @(posedge i_mclk);
      if (rs.arready) rq.arvalid <= 1'b0;
    end while (!rs.rvalid);
    d = rs.rdata;
    rq.rready <= 1'b0;
    `CHK("rresp", a > 4'h8 ? CEF_RESP_SLVERR : CEF_RESP_OKAY, rs.rresp)
    `CHK("rdata", e, d)
  endtask

  task automatic ev(input int i);
    @(posedge i_mclk);
    evt <= cef_events_t'(10'h1 << i);
    @(posedge i_mclk);
    evt <= '0;
  endtask

  // ----
  // Test sequence
  // ----
  initial begin
    repeat (20) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    rc(CEF_OFS_STATUS, CEF_RESET_VAL);
    rc(CEF_OFS_ENABLE, CEF_RESET_VAL);
    wr(CEF_OFS_ENABLE, 32'hFFFFFFFF);
    rc(CEF_OFS_ENABLE, CEF_IMPL_MASK);
    foreach (ix[k]) begin
      ev(ix[k]);
      rc(CEF_OFS_STATUS, 32'h1 << bt[k]);
      `CHK("irq", 1'b1, o_irq)
      wr(CEF_OFS_STATUS, 32'h0);
      rc(CEF_OFS_STATUS, 32'h1 << bt[k]);
      wr(CEF_OFS_STATUS, 32'h1 << bt[k]);
      rc(CEF_OFS_STATUS, 32'h0);
      `CHK("irq", 1'b0, o_irq)
    end
    ev(3);
    ev(3);
    rc(CEF_OFS_STATUS, 32'h14);
    ev(0);
    rc(CEF_OFS_STATUS, 32'h10);
    wr(CEF_OFS_STATUS, 32'h10);
    wr(CEF_OFS_ENABLE, 32'h800);
    ev(7);
    rc(CEF_OFS_STATUS, 32'h200);
    `CHK("irq", 1'b0, o_irq)
    ev(8);
    rc(CEF_OFS_STATUS, 32'hA00);
    `CHK("irq", 1'b1, o_irq)
    wr(CEF_OFS_STATUS, 32'hA00);
    ev(1);
    rc(CEF_OFS_STATUS, 32'h0);
    wr(CEF_OFS_CFGCMD, 32'h2);
    `CHK("enable_cmd", 1'b1, o_enable_cmd)
    ev(1);
    rc(CEF_OFS_STATUS, 32'h1);
    wr(CEF_OFS_STATUS, 32'h1);
    wr(CEF_OFS_CFGCMD, 32'h6);
    wr(CEF_OFS_CFGCMD, 32'h7);
    rc(CEF_OFS_CFGCMD, 32'h6);
    `CHK("cfg_pulses", 1, n_cfg)
    `CHK("start", 1'b0, o_start_cmd)
    ev(9);
    rc(CEF_OFS_STATUS, 32'h2000);
    rc(CEF_OFS_CFGCMD, 32'h2);
    wr(CEF_OFS_STATUS, 32'h2000);
    wr(CEF_OFS_CFGCMD, 32'h3);
    `CHK("start", 1'b1, o_start_cmd)
    wr(CEF_OFS_ENABLE, 32'h0);
    rc(CEF_OFS_ENABLE, 32'h800);
    @(posedge i_mclk);
    stc <= 1'b1;
    @(posedge i_mclk);
    stc <= 1'b0;
    rc(CEF_OFS_CFGCMD, 32'h2);
    wr(4'hC, 32'hFFFFFFFF);
    rc(4'hC, 32'h0);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    rc(CEF_OFS_ENABLE, CEF_RESET_VAL);
    `CHK("irq", 1'b0, o_irq)
    `CHK("enable_cmd", 1'b0, o_enable_cmd)
    print_verdict();
  end
endmodule // converter_event_flags_irq_bench
